/* File: hw/crs_pkg.sv */
// constants shared by the receive buffer search block
package crs_pkg;
    localparam int NB = 8;
    localparam int IDX_W = 3;
    localparam int ID_W = 29;
    localparam int DLC_W = 4;
    localparam int DATA_W = 64;
    localparam int TYPE_W = 3;
    localparam int LINK_W = 3;
    localparam int EV_W = 4;

    // receive type codes and priority levels
    localparam logic [TYPE_W-1:0] RX_TYPE_MIN = 3'h1;
    localparam logic [TYPE_W-1:0] RX_TYPE_MAX = 3'h5;
    localparam logic [LINK_W-1:0] LINK_UNMASKED = 3'h0;
    localparam logic [LINK_W-1:0] LINK_LAST = 3'h4;

    // global register byte offsets
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h004;
    localparam logic [11:0] OFS_LAST = 12'h008;
    // buffer m sits at (BUF_REGION << 8) + m * 0x20
    localparam logic [3:0] BUF_REGION = 4'h1;
    localparam logic [4:0] OFS_BUF_CFG = 5'h00;
    localparam logic [4:0] OFS_BUF_CTL = 5'h04;
    localparam logic [4:0] OFS_BUF_ID = 5'h08;
    localparam logic [4:0] OFS_BUF_DLO = 5'h0c;
    localparam logic [4:0] OFS_BUF_DHI = 5'h10;

    // buffer_config_reg fields
    localparam int CFG_USE_BIT = 0;
    localparam int CFG_TYPE_LSB = 1;
    localparam int CFG_LINK_LSB = 4;
    // buffer_control_reg fields
    localparam int CTL_RDY_BIT = 0;
    localparam int CTL_FULL_BIT = 1;
    localparam int CTL_OW_BIT = 2;
    localparam int CTL_DLC_LSB = 4;
    // status / mask event bits, and the valid bit of the last-store register
    localparam int EV_STORED = 0;
    localparam int EV_OVERWRITE = 1;
    localparam int EV_DISCARD = 2;
    localparam int EV_NOMATCH = 3;
    localparam int LAST_VALID_BIT = 8;

    // reset values
    localparam logic [EV_W-1:0] STATUS_RST = 4'h0;
    localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [TYPE_W-1:0] TYPE_RST = 3'h0;
    localparam logic [LINK_W-1:0] LINK_RST = 3'h0;

    typedef enum logic [1:0] {
        CRS_BUS_IDLE,
        CRS_BUS_WR,
        CRS_BUS_RDWAIT
    } crs_bus_t;
endpackage

/* File: hw/crs_rank.sv */
// fixed-priority pick of one buffer among the candidates
`timescale 1ns/1ps
`default_nettype none
module crs_rank
    import crs_pkg::*;
(
    input wire logic [NB-1:0] cand,
    input wire logic [NB-1:0][LINK_W-1:0] link,
    output logic win_vld,
    output logic [IDX_W-1:0] win_idx
);
    logic [LINK_W-1:0] best;

    // lower link code wins; equal codes go to the lower index
    always_comb begin
        best = LINK_LAST;
        win_vld = 1'b0;
        win_idx = '0;
        for (int i = NB - 1; i >= 0; i--) begin
            if (cand[i] && (!win_vld || link[i] <= best)) begin
                best = link[i];
                win_vld = 1'b1;
                win_idx = IDX_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/crs_rx_search.sv */
// receive buffer search and store, with ahb-lite register access
// What this block does
// - every received frame is checked against the whole buffer array.
// - a buffer joins the search only while its in-use bit is 1.
// - a buffer counts as receive only with type code 001 to 101.
// - a buffer is considered only while its ready bit is 1.
// - unmasked buffers rank first, then those linked to masks 1 to 4.
// - the frame goes only to the top ranked matching buffer.
// - the winner accepts if not full, or full with overwrite enabled.
// - a full winner without overwrite drops the frame, no fallback.
`timescale 1ns/1ps
`default_nettype none
module crs_rx_search
    import crs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // protocol engine side
    input wire logic rx_store,
    input wire logic [ID_W-1:0] rx_id,
    input wire logic [DLC_W-1:0] rx_dlc,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic [NB-1:0] rx_match,
    output logic rx_done,
    output logic rx_accepted,
    output logic [IDX_W-1:0] rx_index,
    output logic irq
);
    // bus state
    crs_bus_t bus_q;
    crs_bus_t bus_d;
    logic [11:0] addr_q;
    logic [31:0] hrdata_q;

    // per-buffer state
    logic [NB-1:0] in_use_q;
    logic [NB-1:0][TYPE_W-1:0] type_q;
    logic [NB-1:0][LINK_W-1:0] link_q;
    logic [NB-1:0] ready_q;
    logic [NB-1:0] full_q;
    logic [NB-1:0] ow_q;
    logic [NB-1:0][ID_W-1:0] id_q;
    logic [NB-1:0][DLC_W-1:0] dlc_q;
    logic [NB-1:0][DATA_W-1:0] data_q;

    // global state
    logic [EV_W-1:0] status_q;
    logic [EV_W-1:0] mask_q;
    logic last_vld_q;
    logic [IDX_W-1:0] last_idx_q;
    logic rx_done_q;
    logic rx_acc_q;
    logic [IDX_W-1:0] rx_idx_q;

    // address helpers, used by both the write and the read path
    function automatic logic in_buf_region(input logic [11:0] a);
        return a[11:8] == BUF_REGION;
    endfunction

    function automatic logic [IDX_W-1:0] buf_of(input logic [11:0] a);
        return a[5 +: IDX_W];
    endfunction

    // ---------------- ahb-lite slave ----------------
    wire addr_take = hsel && htrans[1] && hready;
    wire wr_phase = bus_q == CRS_BUS_WR;
    wire wr_global = wr_phase && !in_buf_region(addr_q);
    wire wr_buf = wr_phase && in_buf_region(addr_q);
    wire [IDX_W-1:0] wr_idx = buf_of(addr_q);
    wire [4:0] wr_off = addr_q[4:0];
    wire wr_status = wr_global && addr_q == OFS_STATUS;
    wire wr_mask = wr_global && addr_q == OFS_IRQ_MASK;

    // reads take one wait state so a write just before is already visible
    always_comb begin
        bus_d = CRS_BUS_IDLE;
        unique case (bus_q)
            CRS_BUS_IDLE,
            CRS_BUS_WR: begin
                if (addr_take) begin
                    bus_d = hwrite ? CRS_BUS_WR : CRS_BUS_RDWAIT;
                end
            end
            CRS_BUS_RDWAIT: bus_d = CRS_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_q <= CRS_BUS_IDLE;
            addr_q <= 12'h000;
        end else begin
            bus_q <= bus_d;
            if (addr_take) begin
                addr_q <= haddr[11:0];
            end
        end
    end

    assign hreadyout = bus_q != CRS_BUS_RDWAIT;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // ---------------- read mux ----------------
    wire [IDX_W-1:0] rd_idx = buf_of(addr_q);
    wire [4:0] rd_off = addr_q[4:0];
    wire [31:0] rd_cfg = {25'h0, link_q[rd_idx], type_q[rd_idx],
                          in_use_q[rd_idx]};
    wire [31:0] rd_ctl = {24'h0, dlc_q[rd_idx], 1'b0, ow_q[rd_idx],
                          full_q[rd_idx], ready_q[rd_idx]};
    wire [31:0] rd_id = {3'h0, id_q[rd_idx]};
    wire [31:0] rd_dlo = data_q[rd_idx][31:0];
    wire [31:0] rd_dhi = data_q[rd_idx][63:32];
    wire [31:0] rd_last = {23'h0, last_vld_q, 5'h0, last_idx_q};
    logic [31:0] rd_val;

    // unmapped addresses read as zero
    always_comb begin
        rd_val = 32'h0;
        if (in_buf_region(addr_q)) begin
            case (rd_off)
                OFS_BUF_CFG: rd_val = rd_cfg;
                OFS_BUF_CTL: rd_val = rd_ctl;
                OFS_BUF_ID: rd_val = rd_id;
                OFS_BUF_DLO: rd_val = rd_dlo;
                OFS_BUF_DHI: rd_val = rd_dhi;
                default: rd_val = 32'h0;
            endcase
        end else begin
            case (addr_q)
                OFS_STATUS: rd_val = {28'h0, status_q};
                OFS_IRQ_MASK: rd_val = {28'h0, mask_q};
                OFS_LAST: rd_val = rd_last;
                default: rd_val = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata_q <= 32'h0;
        end else if (bus_q == CRS_BUS_RDWAIT) begin
            hrdata_q <= rd_val;
        end
    end

    // ---------------- receive search ----------------
    logic [NB-1:0] eligible;
    logic [NB-1:0] cand;
    logic win_vld;
    logic [IDX_W-1:0] win_idx;

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_elig
            // link codes above mask 4 have no rank and never qualify
            assign eligible[g] = in_use_q[g]
                && type_q[g] >= RX_TYPE_MIN
                && type_q[g] <= RX_TYPE_MAX
                && ready_q[g]
                && link_q[g] <= LINK_LAST;
        end
    endgenerate

    // all buffers are scanned on every frame, whatever the mode
    assign cand = eligible & rx_match;

    crs_rank u_rank (
        .cand(cand),
        .link(link_q),
        .win_vld(win_vld),
        .win_idx(win_idx)
    );

    // only the winner is looked at; a refusal is never passed down
    wire win_full = full_q[win_idx];
    wire win_ok = !win_full || ow_q[win_idx];
    wire store = rx_store && win_vld && win_ok;
    wire drop = rx_store && win_vld && !win_ok;
    wire nomatch = rx_store && !win_vld;

    logic [EV_W-1:0] ev;
    always_comb begin
        ev = '0;
        ev[EV_STORED] = store;
        ev[EV_OVERWRITE] = store && win_full;
        ev[EV_DISCARD] = drop;
        ev[EV_NOMATCH] = nomatch;
    end

    // ---------------- per-buffer registers ----------------
    generate
        for (g = 0; g < NB; g++) begin : g_buf
            wire sel = wr_buf && wr_idx == IDX_W'(g);
            wire wr_cfg = sel && wr_off == OFS_BUF_CFG;
            wire wr_ctl = sel && wr_off == OFS_BUF_CTL;
            wire st = store && win_idx == IDX_W'(g);

            always_ff @(posedge clk) begin
                if (srst) begin
                    in_use_q[g] <= 1'b0;
                    type_q[g] <= TYPE_RST;
                    link_q[g] <= LINK_RST;
                end else if (wr_cfg) begin
                    in_use_q[g] <= hwdata[CFG_USE_BIT];
                    type_q[g] <= hwdata[CFG_TYPE_LSB +: TYPE_W];
                    link_q[g] <= hwdata[CFG_LINK_LSB +: LINK_W];
                end
            end

            // a store in the same cycle as a software clear keeps full set
            always_ff @(posedge clk) begin
                if (srst) begin
                    ready_q[g] <= 1'b0;
                    full_q[g] <= 1'b0;
                    ow_q[g] <= 1'b0;
                end else begin
                    if (wr_ctl) begin
                        ready_q[g] <= hwdata[CTL_RDY_BIT];
                        ow_q[g] <= hwdata[CTL_OW_BIT];
                    end
                    if (st) begin
                        full_q[g] <= 1'b1;
                    end else if (wr_ctl) begin
                        full_q[g] <= hwdata[CTL_FULL_BIT];
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    id_q[g] <= '0;
                    dlc_q[g] <= '0;
                    data_q[g] <= '0;
                end else if (st) begin
                    id_q[g] <= rx_id;
                    dlc_q[g] <= rx_dlc;
                    data_q[g] <= rx_data;
                end
            end
        end
    endgenerate

    // ---------------- status, mask, interrupt ----------------
    wire [EV_W-1:0] w1c = wr_status ? hwdata[EV_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= STATUS_RST;
            mask_q <= IRQ_MASK_RST;
        end else begin
            // a new event wins over a write-one-to-clear in the same cycle
            status_q <= (status_q & ~w1c) | ev;
            if (wr_mask) begin
                mask_q <= hwdata[EV_W-1:0];
            end
        end
    end

    assign irq = |(status_q & mask_q);

    // ---------------- engine answer ----------------
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_done_q <= 1'b0;
            rx_acc_q <= 1'b0;
            rx_idx_q <= '0;
            last_vld_q <= 1'b0;
            last_idx_q <= '0;
        end else begin
            rx_done_q <= rx_store;
            rx_acc_q <= store;
            if (rx_store) begin
                rx_idx_q <= win_idx;
            end
            if (store) begin
                last_vld_q <= 1'b1;
                last_idx_q <= win_idx;
            end
        end
    end

    assign rx_done = rx_done_q;
    assign rx_accepted = rx_acc_q;
    assign rx_index = rx_idx_q;
endmodule
`default_nettype wire

/* File: verif/crs_rx_search_properties.sv */
// port assertions for the receive buffer search block
`timescale 1ns/1ps
`default_nettype none
module crs_rx_search_props
    import crs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_store,
    input wire logic [NB-1:0] rx_match,
    input wire logic rx_done,
    input wire logic rx_accepted,
    input wire logic [IDX_W-1:0] rx_index
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wr;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_rd_one_wait: assert property (s_rd |=> s_one_wait)
        else $error("read did not take exactly one wait state");
    a_wr_no_wait: assert property (s_wr |=> hreadyout)
        else $error("write data phase stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_done_follows: assert property (rx_store |=> rx_done)
        else $error("offered frame got no done pulse");
    a_done_cause: assert property (rx_done |-> $past(rx_store))
        else $error("done pulse without an offered frame");
    a_accept_in_done: assert property (rx_accepted |-> rx_done)
        else $error("accept flag outside done pulse");
    a_nomatch_drop: assert property (rx_store && rx_match == '0
        |=> !rx_accepted && rx_index == '0)
        else $error("frame stored with no matching buffer");
    a_index_holds: assert property (!rx_store |=> $stable(rx_index))
        else $error("winner index moved without a frame");
endmodule
bind crs_rx_search crs_rx_search_props chk_u (.clk(clk), .srst(srst),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .rx_store(rx_store),
    .rx_match(rx_match), .rx_done(rx_done), .rx_accepted(rx_accepted),
    .rx_index(rx_index));
`default_nettype wire

/* File: verif/crs_engine_model.sv */
// protocol engine stand-in that offers received frames
`timescale 1ns/1ps
`default_nettype none
module crs_engine_model
    import crs_pkg::*;
(
    input wire logic clk,
    output logic rx_store,
    output logic [ID_W-1:0] rx_id,
    output logic [DLC_W-1:0] rx_dlc,
    output logic [DATA_W-1:0] rx_data,
    output logic [NB-1:0] rx_match
);
    initial begin
        rx_store = 1'b0;
        rx_id = '0;
        rx_dlc = '0;
        rx_data = '0;
        rx_match = '0;
    end
    // fields are inverted outside the strobe so stale values never match
    task automatic offer(input logic [NB-1:0] m, input logic [ID_W-1:0] id);
        @(posedge clk);
        rx_store <= 1'b1;
        rx_match <= m;
        rx_id <= id;
        rx_dlc <= id[3:0];
        rx_data <= {2{id, 3'h0}};
        @(posedge clk);
        rx_store <= 1'b0;
        rx_match <= ~m;
        rx_id <= ~id;
        rx_dlc <= ~id[3:0];
        rx_data <= ~{2{id, 3'h0}};
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the receive buffer search
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import crs_pkg::*;
;
    logic clk = 0, srst = 1, hsel = 0, hwrite = 0;
    logic [1:0] htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic hreadyout, hresp, rx_store, rx_done, rx_accepted, irq;
    logic [IDX_W-1:0] rx_index;
    logic [ID_W-1:0] rx_id;
    logic [DLC_W-1:0] rx_dlc;
    logic [DATA_W-1:0] rx_data;
    logic [NB-1:0] rx_match, use_b, rdy_b, full_b, ow_b;
    logic [2:0] typ_b[NB], lnk_b[NB];
    logic [3:0] ev;
    logic [8:0] lst = '0;
    int n_fail = 0, tests_run = 0, cyc = 0, seed = 32'hfe13;
    always #2 clk = ~clk;
    crs_rx_search dut_u (.clk(clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rx_store(rx_store),
        .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .rx_match(rx_match), .rx_done(rx_done), .rx_accepted(rx_accepted),
        .rx_index(rx_index), .irq(irq));
    crs_engine_model eng_u (.clk(clk), .rx_store(rx_store), .rx_id(rx_id),
        .rx_dlc(rx_dlc), .rx_data(rx_data), .rx_match(rx_match));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // each phase held until hready is seen high at a rising edge
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic [11:0] ba(input int i);
        return 12'h100 + 12'(i * 32);
    endfunction
    function automatic int pick(input logic [NB-1:0] m);
        int w = -1;
        for (int i = 0; i < NB; i++)
            if (m[i] && use_b[i] && rdy_b[i] && typ_b[i] >= 3'h1
                && typ_b[i] <= 3'h5 && lnk_b[i] <= 3'h4
                && (w < 0 || lnk_b[i] < lnk_b[w]))
                w = i;
        return w;
    endfunction
    task automatic frame(input logic [NB-1:0] m);
        int w;
        logic acc;
        logic [ID_W-1:0] id;
        w = pick(m);
        acc = w >= 0 && (!full_b[w] || ow_b[w]);
        id = ID_W'($random(seed));
        eng_u.offer(m, id);
        #1;
        chk(rx_done, 1);
        chk(rx_accepted, acc);
        chk(rx_index, w < 0 ? 0 : w);
        if (w < 0)
            ev[3] = 1'b1;
        else if (!acc)
            ev[2] = 1'b1;
        else begin
            ev[0] = 1'b1;
            if (full_b[w])
                ev[1] = 1'b1;
            full_b[w] = 1'b1;
            lst = {1'b1, 5'h0, 3'(w)};
            bus(0, ba(w) + OFS_BUF_ID, 0);
            chk(rd, {3'h0, id});
            bus(0, ba(w) + OFS_BUF_DLO, 0);
            chk(rd, {id, 3'h0});
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        bus(0, OFS_STATUS, 0);
        chk(rd, 0);
        bus(0, ba(0), 0);
        chk(rd, 0);
        bus(0, 12'h00c, 0);
        chk(rd, 0);
        for (int r = 0; r < 30; r++) begin
            for (int i = 0; i < NB; i++) begin
                rd = $random(seed);
                use_b[i] = rd[0] | rd[1];
                typ_b[i] = rd[4:2];
                lnk_b[i] = rd[7:5];
                rdy_b[i] = rd[8] | rd[9];
                full_b[i] = rd[10];
                ow_b[i] = rd[11];
            end
            if (r == 0) begin
                // full unmasked buffer must still beat an empty mask-1 one
                use_b[1:0] = 2'h3;
                rdy_b[1:0] = 2'h3;
                full_b[1:0] = 2'h2;
                ow_b[1] = 1'b0;
                typ_b[0] = 3'h1;
                typ_b[1] = 3'h5;
                lnk_b[0] = 3'h1;
                lnk_b[1] = 3'h0;
            end
            for (int i = 0; i < NB; i++) begin
                bus(1, ba(i) + OFS_BUF_CFG,
                    {25'h0, lnk_b[i], typ_b[i], use_b[i]});
                bus(1, ba(i) + OFS_BUF_CTL,
                    {29'h0, ow_b[i], full_b[i], rdy_b[i]});
            end
            bus(1, OFS_IRQ_MASK, {28'h0, {4{r[0]}}});
            ev = 4'h0;
            repeat (4)
                frame(r == 0 ? 8'h03 : 8'($random(seed)));
            if (r == 1)
                frame(8'h00);
            for (int i = 0; i < NB; i++) begin
                bus(0, ba(i) + OFS_BUF_CTL, 0);
                chk(rd[2:0], {ow_b[i], full_b[i], rdy_b[i]});
            end
            bus(0, OFS_STATUS, 0);
            chk(rd[3:0], ev);
            chk(irq, r[0] && ev != 4'h0);
            bus(0, OFS_LAST, 0);
            chk(rd, {23'h0, lst});
            bus(1, OFS_STATUS, 32'hf);
            #1;
            chk(irq, 0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
